// ---- omm_pkg.sv ----
// How it works
// - serial port answers only while select low
// - interrupt low while any condition is flagged
// - laser off while off request asserted
// - laser off within 100 ms of request
// - laser on within 100 ms of release
// - standby while power-down input high
// - power-down falling edge fully resets block
// - module-absent output tied low
// - signal-lost output high without input signal
// - writes sampled on rising clock, unprotected only
// - read data changes on falling clock edges
// - data line is two-way open drain
// - memory is individually addressed 8-bit words
// - random and sequential access from 000h
// - live readings readable over serial port
// - alarm and warning flags on range excursion
`default_nettype none
package omm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int TX_OFF_MS     = 100;
  localparam int TX_ON_MS      = 100;
  localparam int TX_OFF_CYCLES = TX_OFF_MS * CLK_MHZ * 1000;
  localparam int TX_ON_CYCLES  = TX_ON_MS * CLK_MHZ * 1000;
  localparam int CNT_W         = 24;
  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam int         NPARAM       = 5;
  localparam logic [6:0] A_HI_ALARM   = 7'h00;
  localparam logic [6:0] A_LO_ALARM   = 7'h05;
  localparam logic [6:0] A_HI_WARN    = 7'h0A;
  localparam logic [6:0] A_LO_WARN    = 7'h0F;
  localparam logic [6:0] A_LIMIT_END  = 7'h14;
  localparam logic [6:0] A_READING    = 7'h20;
  localparam logic [6:0] A_READ_END   = 7'h25;
  localparam logic [6:0] A_FLAGS      = 7'h28;
  localparam logic [6:0] A_FLAGS_END  = 7'h2C;
  localparam logic [6:0] A_STATUS     = 7'h2C;
  localparam logic [6:0] A_USER       = 7'h40;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  // ----------------------------------------------------------------
  // factory limits, one byte per monitored value
  // ----------------------------------------------------------------
  localparam logic [4:0][7:0] HI_ALARM = {5{8'hF0}};
  localparam logic [4:0][7:0] LO_ALARM = {5{8'h10}};
  localparam logic [4:0][7:0] HI_WARN  = {5{8'hE0}};
  localparam logic [4:0][7:0] LO_WARN  = {5{8'h20}};
  // ----------------------------------------------------------------
  // serial port states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_DEV, S_ACK_DEV, S_REG, S_ACK_REG,
    S_WR, S_ACK_WR, S_READ, S_MACK
  } omm_i2c_st_t;
endpackage
`default_nettype wire

// ---- omm_mem_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface omm_mem_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ---- omm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module omm_sync #(
  parameter int W = 6
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } omm_sync_t;
  omm_sync_t s_r;
  omm_sync_t s_nxt;
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = i_async;
    s_nxt.s2 = s_r.s1;
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_sync = s_r.s2;
endmodule // omm_sync
`default_nettype wire

// ---- omm_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module omm_mem
  import omm_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  omm_mem_if.mem    bus
);
  typedef struct packed {
    logic [63:0][7:0] mem;
  } omm_mem_t;
  omm_mem_t s_r;
  omm_mem_t s_nxt;
  // ----------------------------------------------------------------
  // user area, protected space below it
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (bus.we && (bus.addr >= A_USER)) begin
      s_nxt.mem[bus.addr[5:0]] = bus.wdata;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign bus.rdata = s_r.mem[bus.addr[5:0]];
endmodule // omm_mem
`default_nettype wire

// ---- omm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module omm_ctrl
  import omm_pkg::*;
#(
  parameter int         P_TX_OFF_CYCLES = TX_OFF_CYCLES,
  parameter int         P_TX_ON_CYCLES  = TX_ON_CYCLES / 2,
  parameter logic [6:0] P_DEV_ADDR      = DEV_ADDR_DEF
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_select_n,
  input  wire logic       i_laser_off_request,
  input  wire logic       i_power_down,
  input  wire logic       i_signal_lost,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_temperature,
  input  wire logic [7:0] i_laser_bias,
  input  wire logic [7:0] i_tx_power,
  input  wire logic [7:0] i_rx_power,
  input  wire logic [7:0] i_supply_voltage,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  output logic            o_interrupt_n,
  output logic            o_module_absent,
  output logic            o_not_ready_flag,
  output logic            o_receive_signal_lost,
  output logic            o_laser_enable,
  output logic            o_standby
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    omm_i2c_st_t      st;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic [7:0]       tx;
    logic [6:0]       ptr;
    logic             rw;
    logic             drive;
    logic             we;
    logic [7:0]       wdata;
    logic             scl_q;
    logic             sda_q;
    logic             pd_q;
    logic             laser_en;
    logic [CNT_W-1:0] cnt;
    logic [4:0][7:0]  rd;
    logic [3:0][4:0]  flags;
    logic             lost;
    logic             irq_n;
    logic             nready;
    logic             standby;
  } omm_ctrl_t;

  omm_ctrl_t  s_r;
  omm_ctrl_t  s_nxt;
  logic [5:0] sy;
  logic       scl;
  logic       sda;
  logic       sel_n;
  logic       off_req;
  logic       pd;
  logic       lost_in;
  logic       pd_fall;
  logic       rst_int_n;
  logic [4:0] f_hi_alarm;
  logic [4:0] f_lo_alarm;
  logic [4:0] f_hi_warn;
  logic [4:0] f_lo_warn;
  logic [7:0] rdb;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  omm_mem_if mbus ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  omm_sync #(
    .W(6)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_signal_lost, i_power_down, i_laser_off_request,
                 i_select_n, i_sda, i_scl}),
    .o_sync    (sy)
  );
  assign scl     = sy[0];
  assign sda     = sy[1];
  assign sel_n   = sy[2];
  assign off_req = sy[3];
  assign pd      = sy[4];
  assign lost_in = sy[5];

  // ----------------------------------------------------------------
  // power-down edge reset
  // ----------------------------------------------------------------
  assign pd_fall   = s_r.pd_q & ~pd;
  assign rst_int_n = i_resetn & ~pd_fall;

  // ----------------------------------------------------------------
  // management memory
  // ----------------------------------------------------------------
  assign mbus.addr  = s_r.ptr;
  assign mbus.wdata = s_r.wdata;
  assign mbus.we    = s_r.we;

  omm_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (rst_int_n),
    .bus       (mbus.mem)
  );

  // ----------------------------------------------------------------
  // range checks per monitored value
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPARAM; p++) begin : g_chk
      assign f_hi_alarm[p] = s_r.rd[p] > HI_ALARM[p];
      assign f_lo_alarm[p] = s_r.rd[p] < LO_ALARM[p];
      assign f_hi_warn[p]  = s_r.rd[p] > HI_WARN[p];
      assign f_lo_warn[p]  = s_r.rd[p] < LO_WARN[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  always_comb begin
    rdb = 8'h00;
    if (s_r.ptr < A_LO_ALARM) begin
      rdb = HI_ALARM[3'(s_r.ptr - A_HI_ALARM)];
    end else if (s_r.ptr < A_HI_WARN) begin
      rdb = LO_ALARM[3'(s_r.ptr - A_LO_ALARM)];
    end else if (s_r.ptr < A_LO_WARN) begin
      rdb = HI_WARN[3'(s_r.ptr - A_HI_WARN)];
    end else if (s_r.ptr < A_LIMIT_END) begin
      rdb = LO_WARN[3'(s_r.ptr - A_LO_WARN)];
    end else if (s_r.ptr >= A_READING && s_r.ptr < A_READ_END) begin
      rdb = s_r.rd[3'(s_r.ptr - A_READING)];
    end else if (s_r.ptr >= A_FLAGS && s_r.ptr < A_FLAGS_END) begin
      rdb = {3'h0, s_r.flags[2'(s_r.ptr - A_FLAGS)]};
    end else if (s_r.ptr == A_STATUS) begin
      rdb = {5'h00, ~s_r.laser_en, s_r.nready, s_r.lost};
    end else if (s_r.ptr >= A_USER) begin
      rdb = mbus.rdata;
    end
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  assign rise  = scl & ~s_r.scl_q;
  assign fall  = ~scl & s_r.scl_q;
  assign start = scl & s_r.scl_q & s_r.sda_q & ~sda;
  assign stop  = scl & s_r.scl_q & ~s_r.sda_q & sda;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.we    = 1'b0;
    s_nxt.scl_q = scl;
    s_nxt.sda_q = sda;
    s_nxt.pd_q  = pd;
    if (sel_n || stop) begin
      s_nxt.st    = S_IDLE;
      s_nxt.drive = 1'b0;
    end else if (start) begin
      s_nxt.st     = S_DEV;
      s_nxt.bitcnt = 4'h0;
      s_nxt.drive  = 1'b0;
    end else if (rise) begin
      case (s_r.st)
        S_DEV, S_REG, S_WR: begin
          s_nxt.shreg  = {s_r.shreg[6:0], sda};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end

        S_READ: begin
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end

        S_MACK: begin
          s_nxt.ptr = s_r.ptr + 7'h01;
          if (sda) begin
            s_nxt.st = S_IDLE;
          end
        end
        default: begin
          s_nxt.st = s_r.st;
        end
      endcase
    end else if (fall) begin
      case (s_r.st)
        S_DEV: begin
          if (s_r.bitcnt == BITS_BYTE) begin
            if (s_r.shreg[7:1] == P_DEV_ADDR) begin
              s_nxt.st    = S_ACK_DEV;
              s_nxt.rw    = s_r.shreg[0];
              s_nxt.drive = 1'b1;
            end else begin
              s_nxt.st = S_IDLE;
            end
          end
        end

        S_ACK_DEV: begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rw) begin
            s_nxt.st    = S_READ;
            s_nxt.tx    = rdb;
            s_nxt.drive = ~rdb[7];
          end else begin
            s_nxt.st    = S_REG;
            s_nxt.drive = 1'b0;
          end
        end

        S_REG: begin
          if (s_r.bitcnt == BITS_BYTE) begin
            s_nxt.ptr   = s_r.shreg[6:0];
            s_nxt.drive = 1'b1;
            s_nxt.st    = S_ACK_REG;
          end
        end

        S_ACK_REG: begin
          s_nxt.drive  = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.st     = S_WR;
        end

        S_WR: begin
          if (s_r.bitcnt == BITS_BYTE) begin
            s_nxt.we    = 1'b1;
            s_nxt.wdata = s_r.shreg;
            s_nxt.drive = 1'b1;
            s_nxt.st    = S_ACK_WR;
          end
        end

        S_ACK_WR: begin
          s_nxt.drive  = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.ptr    = s_r.ptr + 7'h01;
          s_nxt.st     = S_WR;
        end

        S_READ: begin
          if (s_r.bitcnt == BITS_BYTE) begin
            s_nxt.drive = 1'b0;
            s_nxt.st    = S_MACK;
          end else begin
            s_nxt.tx    = {s_r.tx[6:0], 1'b0};
            s_nxt.drive = ~s_r.tx[6];
          end
        end

        S_MACK: begin
          s_nxt.st     = S_READ;
          s_nxt.bitcnt = 4'h0;
          s_nxt.tx     = rdb;
          s_nxt.drive  = ~rdb[7];
        end
        default: begin
          s_nxt.drive = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // laser control
    // ----------------------------------------------------------------
    s_nxt.standby = pd;
    if (off_req || pd) begin
      s_nxt.laser_en = 1'b0;
      s_nxt.cnt      = '0;
    end else if (!s_r.laser_en) begin
      if (s_r.cnt == CNT_W'(P_TX_ON_CYCLES - 1)) begin
        s_nxt.laser_en = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
    end
    s_nxt.nready = pd | (~off_req & ~s_r.laser_en);

    // ----------------------------------------------------------------
    // monitoring
    // ----------------------------------------------------------------
    s_nxt.rd[0]    = i_temperature;
    s_nxt.rd[1]    = i_laser_bias;
    s_nxt.rd[2]    = i_tx_power;
    s_nxt.rd[3]    = i_rx_power;
    s_nxt.rd[4]    = i_supply_voltage;
    s_nxt.flags[0] = f_hi_alarm;
    s_nxt.flags[1] = f_lo_alarm;
    s_nxt.flags[2] = f_hi_warn;
    s_nxt.flags[3] = f_lo_warn;
    s_nxt.lost     = lost_in;
    s_nxt.irq_n    = ~(lost_in | (|s_r.flags));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!rst_int_n) begin
      s_r       <= '0;
      s_r.irq_n <= 1'b1;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_sda                 = 1'b0;
  assign o_sda_oe_n            = ~s_r.drive;

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  assign o_interrupt_n         = s_r.irq_n;
  assign o_module_absent       = 1'b0;
  assign o_not_ready_flag      = s_r.nready;
  assign o_receive_signal_lost = s_r.lost;
  assign o_laser_enable        = s_r.laser_en;
  assign o_standby             = s_r.standby;

endmodule // omm_ctrl
`default_nettype wire

// ---- omm_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module omm_ctrl_props #(
  parameter int P_TX_ON_CYCLES = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_select_n,
  input wire logic i_laser_off_request,
  input wire logic i_power_down,
  input wire logic i_signal_lost,
  input wire logic i_scl,
  input wire logic o_sda_oe_n,
  input wire logic o_interrupt_n,
  input wire logic o_module_absent,
  input wire logic o_receive_signal_lost,
  input wire logic o_laser_enable,
  input wire logic o_standby
);
  localparam int ON_MAX = P_TX_ON_CYCLES + 24;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  chk_absent_tied_low: assert property (o_module_absent == 1'h0)
    else $error("module absent not low");
  chk_loss_follows: assert property ((i_signal_lost && !i_power_down) [*6] |-> o_receive_signal_lost)
    else $error("signal lost not reported");
  chk_int_on_loss: assert property (o_receive_signal_lost [*3] |-> !o_interrupt_n)
    else $error("interrupt missing on loss");
  chk_laser_goes_off: assert property (i_laser_off_request [*4] |-> !o_laser_enable)
    else $error("laser still on");
  chk_laser_settles: assert property ($fell(i_laser_off_request) |-> !o_laser_enable [*8])
    else $error("laser back too early");
  chk_laser_on_bound: assert property ($fell(i_laser_off_request) && !i_power_down
    |-> ##[1:ON_MAX] o_laser_enable)
    else $error("laser not back in time");
  chk_standby_held: assert property (i_power_down [*4] |-> o_standby)
    else $error("standby missing");
  chk_deselect_quiet: assert property (i_select_n [*8] |-> o_sda_oe_n)
    else $error("data driven while deselected");
  chk_drive_on_fall: assert property ($fell(o_sda_oe_n) |->
    ($past(i_scl, 3) && !$past(i_scl, 2)) || ($past(i_scl, 4) && !$past(i_scl, 3)) ||
    ($past(i_scl, 5) && !$past(i_scl, 4)) || ($past(i_scl, 6) && !$past(i_scl, 5)))
    else $error("data changed away from clock fall");
endmodule // omm_ctrl_props
bind omm_ctrl omm_ctrl_props #(.P_TX_ON_CYCLES(P_TX_ON_CYCLES)) u_props (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_select_n(i_select_n),
  .i_laser_off_request(i_laser_off_request), .i_power_down(i_power_down),
  .i_signal_lost(i_signal_lost), .i_scl(i_scl), .o_sda_oe_n(o_sda_oe_n),
  .o_interrupt_n(o_interrupt_n), .o_module_absent(o_module_absent),
  .o_receive_signal_lost(o_receive_signal_lost), .o_laser_enable(o_laser_enable),
  .o_standby(o_standby)
);
`default_nettype wire

// ---- omm_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// two-wire host master, clock idles high between frames
// ----------------------------------------------------------------
module omm_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_sda_line,
  output var logic  o_scl,
  output var logic  o_sda
);
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic start();
    wt(2);
    o_sda = 1'h1;
    wt(6);
    o_scl = 1'h1;
    wt(4);
    o_sda = 1'h0;
    wt(4);
    o_scl = 1'h0;
  endtask
  task automatic stop();
    wt(4);
    o_sda = 1'h0;
    wt(2);
    o_scl = 1'h1;
    wt(4);
    o_sda = 1'h1;
    wt(4);
  endtask
  // one bit, 80 ns period, sampled at the end of the high phase
  task automatic xfer(input logic b, output logic s);
    wt(2);
    o_sda = b;
    wt(2);
    o_scl = 1'h1;
    wt(4);
    s = i_sda_line;
    o_scl = 1'h0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], s);
    end
    xfer(1'h1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'h1, s);
      d[i] = s;
    end
    xfer(last, s);
  endtask
endmodule // omm_host_model
`default_nettype wire

// ---- tb_optical_module_mgmt_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_optical_module_mgmt_control;
  import omm_pkg::*;
  localparam int ON_CYC = 16;
  logic            clk;
  logic            rstn;
  logic            sel_n;
  logic            off_req;
  logic            pd;
  logic            lost_in;
  logic [4:0][7:0] rdg;
  logic [7:0]      rbuf [5];
  wire             scl;
  wire             host_sda;
  wire             sda_o;
  wire             sda_oe_n;
  wire             int_n;
  wire             absent;
  wire             nr;
  wire             lost;
  wire             laser;
  wire             stby;
  wire             sda_line = host_sda & (sda_oe_n | sda_o);
  int              fail_count = 0;
  int              checks_done = 0;
  omm_host_model host (.i_ref_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(host_sda));
  omm_ctrl #(.P_TX_ON_CYCLES(ON_CYC)) dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_select_n(sel_n), .i_laser_off_request(off_req),
    .i_power_down(pd), .i_signal_lost(lost_in), .i_scl(scl), .i_sda(sda_line),
    .i_temperature(rdg[0]), .i_laser_bias(rdg[1]), .i_tx_power(rdg[2]),
    .i_rx_power(rdg[3]), .i_supply_voltage(rdg[4]), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
    .o_interrupt_n(int_n), .o_module_absent(absent), .o_not_ready_flag(nr),
    .o_receive_signal_lost(lost), .o_laser_enable(laser), .o_standby(stby)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic open(input logic [6:0] a);
    logic ack;
    host.start();
    host.wbyte({DEV_ADDR_DEF, 1'h0}, ack);
    check("dev ack", {7'h00, ack}, 8'h01);
    host.wbyte({1'h0, a}, ack);
    check("ptr ack", {7'h00, ack}, 8'h01);
  endtask
  task automatic wr_mem(input logic [6:0] a, input logic [1:0][7:0] d, input int n);
    logic ack;
    open(a);
    for (int i = 0; i < n; i++) begin
      host.wbyte(d[i], ack);
      check("data ack", {7'h00, ack}, 8'h01);
    end
    host.stop();
  endtask
  task automatic rd_mem(input logic [6:0] a, input int n);
    logic ack;
    open(a);
    host.start();
    host.wbyte({DEV_ADDR_DEF, 1'h1}, ack);
    check("read ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, rbuf[i]);
    end
    host.stop();
  endtask
  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'h0;
    sel_n = 1'h0;
    off_req = 1'h0;
    pd = 1'h0;
    lost_in = 1'h0;
    rdg = {8'h84, 8'h83, 8'h82, 8'h81, 8'h80};
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    repeat (40) @(negedge clk);
    check("absent", {7'h00, absent}, 8'h00);
    wr_mem(7'h40, {8'hC3, 8'h5A}, 2);
    rd_mem(7'h40, 2);
    check("ram 40", rbuf[0], 8'h5A);
    check("ram 41", rbuf[1], 8'hC3);
    wr_mem(7'h00, {8'h00, 8'h55}, 1);
    rd_mem(7'h00, 1);
    check("limit kept", rbuf[0], 8'hF0);
    rd_mem(A_READING, 5);
    for (int i = 0; i < 5; i++) begin
      check("reading", rbuf[i], rdg[i]);
    end
    check("int idle", {7'h00, int_n}, 8'h01);
    rdg[0] = 8'hFF;
    rdg[1] = 8'h00;
    repeat (6) @(negedge clk);
    check("int flag", {7'h00, int_n}, 8'h00);
    rd_mem(A_FLAGS, 4);
    for (int i = 0; i < 4; i++) begin
      check("flags", rbuf[i], i[0] ? 8'h02 : 8'h01);
    end
    rdg = {8'h84, 8'h83, 8'h82, 8'h81, 8'h80};
    sel_n = 1'h1;
    repeat (6) @(negedge clk);
    host.start();
    host.wbyte({DEV_ADDR_DEF, 1'h0}, rbuf[0][0]);
    check("deselect ack", {7'h00, rbuf[0][0]}, 8'h00);
    host.stop();
    sel_n = 1'h0;
    off_req = 1'h1;
    repeat (5) @(negedge clk);
    check("laser off", {7'h00, laser}, 8'h00);
    off_req = 1'h0;
    repeat (8) @(negedge clk);
    check("laser wait", {6'h00, nr, laser}, 8'h02);
    repeat (ON_CYC + 8) @(negedge clk);
    check("laser on", {6'h00, nr, laser}, 8'h01);
    lost_in = 1'h1;
    repeat (6) @(negedge clk);
    check("loss", {6'h00, lost, int_n}, 8'h02);
    lost_in = 1'h0;
    repeat (6) @(negedge clk);
    check("no loss", {7'h00, lost}, 8'h00);
    pd = 1'h1;
    repeat (5) @(negedge clk);
    check("standby", {6'h00, stby, laser}, 8'h02);
    pd = 1'h0;
    repeat (8) @(negedge clk);
    rd_mem(7'h40, 1);
    check("ram cleared", rbuf[0], 8'h00);
    check("awake", {7'h00, stby}, 8'h00);
    wrap_up();
  end
endmodule // tb_optical_module_mgmt_control
`default_nettype wire
